// ===== spsp_pkg.sv
// Constants for the serial port block
// How it works
// - Bytes shift MSB first on data lines
// - Master starts; slave answers on master clock
// - Four polarity/phase modes, both ends equal
// - Master drives clock at selected rate
// - Low select as master forces master and enable off
// - Master data write loads and starts shifting
// - Slave data write loads shift register
// - Slave starts on master clock edges
// - Byte end sets done flag, interrupt
// - Done clears: status access, then data read (or data write as slave)
// - Data writes ignored until status read
// - Data write during transfer sets collision
// - Byte while done set raises overrun
// - Low select as master sets mode fault
// - Output disable releases data output pin
// - Soft management ignores select pin
// - Internal select bit: 0 selected
// - Received byte copied to read buffer
package spsp_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BYTE_W = 8;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_DATA        = 8'h04;
    localparam logic [7:0] OFS_CONTROL     = 8'h08;
    localparam logic [7:0] CSR_RESET       = 8'h00;
    localparam logic [7:0] CTL_RESET       = 8'h00;
    localparam logic [7:0] RXBUF_RESET     = 8'h00;
    // ----------------------------------------
    // Status bits
    // ----------------------------------------
    localparam int unsigned CSR_DONE = 7;
    localparam int unsigned CSR_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned CSR_OVR  = 5;
    localparam int unsigned CSR_MODE_FAULT_FLAG = 4;
    localparam int unsigned CSR_SOD  = 2;
    localparam int unsigned CSR_SSM  = 1;
    localparam int unsigned CSR_SSI  = 0;
    // ----------------------------------------
    // Control bits
    // ----------------------------------------
    localparam int unsigned CTL_IRQEN  = 7;
    localparam int unsigned CTL_ENABLE = 6;
    localparam int unsigned CTL_MASTER = 5;
    localparam int unsigned CTL_CLOCK_POLARITY   = 4;
    localparam int unsigned CTL_CLOCK_PHASE   = 3;
    localparam int unsigned CTL_RATE_H = 2;
    localparam int unsigned CTL_RATE_L = 0;
    // ----------------------------------------
    // Serial timing
    // ----------------------------------------
    localparam logic [4:0] EDGES_LAST = 5'h0F;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam int unsigned PIN_SCK  = 3;
    localparam int unsigned PIN_MOSI = 2;
    localparam int unsigned PIN_MISO = 1;
    localparam int unsigned PIN_SS   = 0;
    localparam int unsigned PIN_N    = 4;
    typedef enum logic [0:0] {SCK_IDLE, SCK_RUN} spsp_sck_state_type;
endpackage

// ===== spsp_shift_if.sv
// Shift engine control and result signals
`timescale 1ns/1ns
interface spsp_shift_if;
    import spsp_pkg::*;
    logic              load;
    logic [BYTE_W-1:0] load_data;
    logic              sample;
    logic              launch;
    logic              abort;
    logic              clock_phase;
    logic              serial_in;
    logic              out_bit;
    logic              busy;
    logic              done;
    logic [BYTE_W-1:0] rx_byte;
    modport ctl (output load, load_data, sample, launch, abort, clock_phase, serial_in,
                 input out_bit, busy, done, rx_byte);
    modport sft (input load, load_data, sample, launch, abort, clock_phase, serial_in,
                 output out_bit, busy, done, rx_byte);
endinterface

// ===== spsp_shifter.sv
// Byte shift engine shared by master and slave
`timescale 1ns/1ns
module spsp_shifter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Engine control
    spsp_shift_if.sft sh
);
    import spsp_pkg::*;
    logic [BYTE_W-1:0] sr;
    logic [2:0]        cnt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr         <= RXBUF_RESET;
            cnt        <= 3'h0;
            sh.out_bit <= 1'b0;
            sh.busy    <= 1'b0;
            sh.done    <= 1'b0;
            sh.rx_byte <= RXBUF_RESET;
        end else begin
            sh.done <= 1'b0;
            // Load wins so a deselected slave still takes its next byte
            if (sh.load) begin
                sr         <= sh.load_data;
                sh.out_bit <= sh.load_data[BYTE_W-1];
                cnt        <= 3'h0;
                sh.busy    <= !sh.abort;
            end else if (sh.abort) begin
                cnt     <= 3'h0;
                sh.busy <= 1'b0;
            end else begin
                if (sh.launch) begin
                    sh.out_bit <= sr[BYTE_W-1];
                    if (sh.clock_phase) begin
                        sh.busy <= 1'b1;
                    end
                end
                if (sh.sample) begin
                    sr <= {sr[BYTE_W-2:0], sh.serial_in};
                    if (cnt == BIT_LAST) begin
                        cnt        <= 3'h0;
                        sh.done    <= 1'b1;
                        sh.busy    <= 1'b0;
                        sh.rx_byte <= {sr[BYTE_W-2:0], sh.serial_in};
                    end else begin
                        cnt     <= cnt + 3'h1;
                        sh.busy <= 1'b1;
                    end
                end
            end
        end
    end

    chk_eighth_sample_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sh.sample && !sh.abort && !sh.load && cnt == BIT_LAST) |=> sh.done && !sh.busy)
        else $error("byte end not flagged after eighth sample");
    chk_load_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sh.load && !sh.abort) |=> (sh.out_bit == $past(sh.load_data[BYTE_W-1])) && sh.busy)
        else $error("loaded byte does not present its top bit");
endmodule

// ===== spsp_port.sv
// Serial port top: APB registers, clocking, flags, pins
`timescale 1ns/1ns
module spsp_port #(
    parameter int unsigned HALF_BASE = 1
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    // APB slave
    input  wire logic [spsp_pkg::ADDR_W-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Interrupt
    input  wire logic                        cpu_irq_mask,
    output logic                             irq_req,
    // Serial clock pin
    input  wire logic                        sck_in,
    output logic                             sck_out,
    output logic                             sck_oe,
    // Data pins
    input  wire logic                        mosi_in,
    output logic                             mosi_out,
    output logic                             mosi_oe,
    input  wire logic                        miso_in,
    output logic                             miso_out,
    output logic                             miso_oe,
    // Slave select pin
    input  wire logic                        ss_n_in
);
    import spsp_pkg::*;

    if (HALF_BASE < 1 || HALF_BASE > 2) begin : g_half_check
        $error("HALF_BASE must be 1 or 2");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic             sck_prev;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
            sck_prev <= 1'b0;
        end else begin
            pin_meta <= {sck_in, mosi_in, miso_in, ss_n_in};
            pin_sync <= pin_meta;
            sck_prev <= pin_sync[PIN_SCK];
        end
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0]        ctrl;
    logic              output_disable;
    logic              select_soft_manage;
    logic              internal_select_level;
    logic              done_flag;
    logic              write_collision_flag;
    logic              overrun_flag;
    logic              mode_fault_flag;
    logic [BYTE_W-1:0] rx_buf;
    logic              acc_seen;
    logic              rd_seen;
    logic              write_collision_flag_seen;
    logic              mode_fault_flag_seen;

    spsp_shift_if sh ();

    spsp_shifter u_shifter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sh      (sh)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic       fin;
    logic       hit;
    logic       wr_csr;
    logic       acc_csr;
    logic       rd_csr;
    logic       wr_data;
    logic       rd_data;
    logic       wr_ctl;
    logic [7:0] rd_mux;

    assign fin     = psel & penable & pready;
    assign acc_csr = fin & (paddr == OFS_CTRL_STATUS);
    assign wr_csr  = acc_csr & pwrite;
    assign rd_csr  = acc_csr & ~pwrite;
    assign wr_data = fin & pwrite & (paddr == OFS_DATA);
    assign rd_data = fin & ~pwrite & (paddr == OFS_DATA);
    assign wr_ctl  = fin & pwrite & (paddr == OFS_CONTROL);

    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        case (paddr)
            OFS_CTRL_STATUS: rd_mux = {done_flag, write_collision_flag, overrun_flag, mode_fault_flag, 1'b0, output_disable, select_soft_manage, internal_select_level};
            OFS_DATA:        rd_mux = rx_buf;
            OFS_CONTROL:     rd_mux = ctrl;
            default:         hit = 1'b0;
        endcase
    end

    // Two-phase answer: pready rises one cycle into access
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            if (psel && penable && !pready) begin
                prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_mux};
            end
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic       is_master;
    logic       en;
    logic       clock_polarity;
    logic       clock_phase;
    logic       ss_eff_n;
    logic       fault;
    logic       slave_act;
    logic       inhibit;
    logic       done_clr;
    logic [2:0] rate;

    assign is_master = ctrl[CTL_MASTER];
    assign en        = ctrl[CTL_ENABLE];
    assign clock_polarity      = ctrl[CTL_CLOCK_POLARITY];
    assign clock_phase      = ctrl[CTL_CLOCK_PHASE];
    assign rate      = ctrl[CTL_RATE_H:CTL_RATE_L];
    assign ss_eff_n  = select_soft_manage ? internal_select_level : pin_sync[PIN_SS];
    assign fault     = is_master & ~ss_eff_n;
    assign slave_act = en & ~is_master & ~ss_eff_n;
    assign inhibit   = done_flag & ~rd_seen;
    assign done_clr  = acc_seen & (rd_data | (wr_data & ~is_master));

    // ----------------------------------------
    // Control and select registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTL_RESET;
        end else if (fault) begin
            ctrl[CTL_MASTER] <= 1'b0;
            ctrl[CTL_ENABLE] <= 1'b0;
        end else if (wr_ctl) begin
            ctrl <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_disable <= CSR_RESET[CSR_SOD];
            select_soft_manage <= CSR_RESET[CSR_SSM];
            internal_select_level <= CSR_RESET[CSR_SSI];
        end else if (wr_csr) begin
            output_disable <= pwdata[CSR_SOD];
            select_soft_manage <= pwdata[CSR_SSM];
            internal_select_level <= pwdata[CSR_SSI];
        end
    end

    // ----------------------------------------
    // Shift start
    // ----------------------------------------
    logic load_ok;

    assign load_ok      = wr_data & ~inhibit & ~sh.busy & en;
    assign sh.load      = load_ok;
    assign sh.load_data = pwdata[BYTE_W-1:0];
    assign sh.clock_phase      = clock_phase;
    assign sh.abort     = ~en | (~is_master & ss_eff_n);
    assign sh.serial_in = is_master ? pin_sync[PIN_MISO] : pin_sync[PIN_MOSI];

    // ----------------------------------------
    // Master clock generator
    // ----------------------------------------
    spsp_sck_state_type sck_state;
    logic [8:0]         div_cnt;
    logic [8:0]         half_len;
    logic [4:0]         edge_cnt;
    logic               tick;

    assign half_len = 9'(HALF_BASE) << rate;
    assign tick     = (sck_state == SCK_RUN) && (div_cnt == half_len - 9'h001);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_state <= SCK_IDLE;
            div_cnt   <= 9'h000;
            edge_cnt  <= 5'h00;
            sck_out   <= 1'b0;
        end else if (sh.abort || !is_master) begin
            sck_state <= SCK_IDLE;
            div_cnt   <= 9'h000;
            edge_cnt  <= 5'h00;
            sck_out   <= clock_polarity;
        end else begin
            case (sck_state)
                SCK_IDLE: begin
                    sck_out <= clock_polarity;
                    if (load_ok) begin
                        sck_state <= SCK_RUN;
                        div_cnt   <= 9'h000;
                        edge_cnt  <= 5'h00;
                    end
                end
                SCK_RUN: begin
                    if (tick) begin
                        div_cnt  <= 9'h000;
                        sck_out  <= ~sck_out;
                        edge_cnt <= edge_cnt + 5'h01;
                        if (edge_cnt == EDGES_LAST) begin
                            sck_state <= SCK_IDLE;
                        end
                    end else begin
                        div_cnt <= div_cnt + 9'h001;
                    end
                end
                default: begin
                    sck_state <= SCK_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Edge events
    // ----------------------------------------
    logic s_edge;
    logic lead;
    logic trail;

    assign s_edge = pin_sync[PIN_SCK] != sck_prev;
    always_comb begin
        if (is_master) begin
            lead  = tick & ~edge_cnt[0];
            trail = tick & edge_cnt[0];
        end else begin
            lead  = slave_act & s_edge & (pin_sync[PIN_SCK] != clock_polarity);
            trail = slave_act & s_edge & (pin_sync[PIN_SCK] == clock_polarity);
        end
    end
    assign sh.sample = clock_phase ? trail : lead;
    assign sh.launch = clock_phase ? lead : trail;

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_flag <= CSR_RESET[CSR_DONE];
            acc_seen  <= 1'b0;
            rd_seen   <= 1'b0;
        end else begin
            if (sh.done) begin
                done_flag <= 1'b1;
            end else if (done_clr) begin
                done_flag <= 1'b0;
            end
            if (done_clr || !done_flag) begin
                acc_seen <= 1'b0;
                rd_seen  <= 1'b0;
            end else begin
                acc_seen <= acc_seen | acc_csr;
                rd_seen  <= rd_seen | rd_csr;
            end
        end
    end

    // Buffer keeps the unread byte on overrun
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buf <= RXBUF_RESET;
        end else if (sh.done && !done_flag) begin
            rx_buf <= sh.rx_byte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_collision_flag      <= CSR_RESET[CSR_WRITE_COLLISION_FLAG];
            write_collision_flag_seen <= 1'b0;
        end else begin
            if (wr_data && !inhibit && sh.busy) begin
                write_collision_flag <= 1'b1;
            end else if (write_collision_flag_seen && (rd_data || wr_data)) begin
                write_collision_flag <= 1'b0;
            end
            if (write_collision_flag_seen && (rd_data || wr_data)) begin
                write_collision_flag_seen <= 1'b0;
            end else if (acc_csr && write_collision_flag) begin
                write_collision_flag_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_flag <= CSR_RESET[CSR_OVR];
        end else if (sh.done && done_flag) begin
            overrun_flag <= 1'b1;
        end else if (rd_csr) begin
            overrun_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_fault_flag      <= CSR_RESET[CSR_MODE_FAULT_FLAG];
            mode_fault_flag_seen <= 1'b0;
        end else begin
            if (fault) begin
                mode_fault_flag <= 1'b1;
            end else if (mode_fault_flag_seen && wr_ctl) begin
                mode_fault_flag <= 1'b0;
            end
            if (!mode_fault_flag || (mode_fault_flag_seen && wr_ctl && !fault)) begin
                mode_fault_flag_seen <= 1'b0;
            end else if (acc_csr) begin
                mode_fault_flag_seen <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Pin and interrupt outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_oe   <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe  <= 1'b0;
            miso_out <= 1'b0;
            miso_oe  <= 1'b0;
            irq_req  <= 1'b0;
        end else begin
            sck_oe   <= en & is_master;
            mosi_out <= sh.out_bit;
            miso_out <= sh.out_bit;
            mosi_oe  <= en & is_master & ~output_disable;
            miso_oe  <= slave_act & ~output_disable;
            irq_req  <= ctrl[CTL_IRQEN] & ~cpu_irq_mask & (done_flag | overrun_flag | mode_fault_flag);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_done_after_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sh.done |=> done_flag)
        else $error("done flag not set after byte");
    chk_irq_from_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (done_flag && ctrl[CTL_IRQEN] && !cpu_irq_mask) |=> irq_req)
        else $error("enabled done flag gave no interrupt");
    chk_inhibit_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_data && done_flag && !rd_seen) |-> !sh.load ##1 !write_collision_flag || $past(write_collision_flag))
        else $error("data write not ignored while done set");
    chk_write_collision_flag_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_data && sh.busy && !inhibit) |=> write_collision_flag && !$past(sh.load))
        else $error("collision not flagged");
    chk_fault_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fault |=> mode_fault_flag && !is_master && !en ##1 !sck_oe)
        else $error("mode fault did not drop master role");
    chk_ovr_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sh.done && done_flag) |=> overrun_flag && $stable(rx_buf))
        else $error("overrun not flagged or buffer overwritten");
    chk_rxbuf_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sh.done && !done_flag) |=> rx_buf == $past(sh.rx_byte))
        else $error("received byte not buffered");
    chk_sod_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        output_disable |=> !mosi_oe && !miso_oe)
        else $error("data output driven while disabled");
    chk_done_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (done_flag && !acc_seen && !sh.done) |=> done_flag)
        else $error("done cleared without status access");
endmodule

// ===== spsp_far_slave.sv
// Far-side serial slave model for master-role traffic
`timescale 1ns/1ns
module spsp_far_slave (
    // Serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Setup from the bench
    input  wire logic       clock_polarity,
    input  wire logic       clock_phase,
    input  wire logic       arm,
    input  wire logic [7:0] tx,
    output logic [7:0]      rx
);
    int         k;
    logic [7:0] sh;
    initial begin
        k = 8;
        sh = 8'h00;
        rx = 8'h00;
        miso = 1'h0;
    end
    // Reload before each frame; phase 1 waits for the first edge
    always @(posedge arm) begin
        k = 0;
        sh = tx;
        miso = clock_phase ? ~miso : tx[7];
    end
    // Sample and launch edges follow polarity and phase
    always @(sck) begin
        if (k < 8) begin
            if ((sck != clock_polarity) != clock_phase) begin
                rx = {rx[6:0], mosi};
                k++;
            end else begin
                miso = sh[7 - k];
            end
        end
    end
endmodule

// ===== spsp_port_bench.sv
// Self-checking bench for the serial port in master and slave roles
`timescale 1ns/1ns
module spsp_port_bench;
    import spsp_pkg::*;
    logic        sys_clk, rst_n, psel, penable, pwrite, cpu_irq_mask, ss_n_in, arm, pcpol, pcpha;
    logic        pready, pslverr, irq_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic        far_miso, err;
    logic [7:0]  paddr, tx, rx;
    logic [31:0] pwdata, prdata, q;
    int          fail_count, check_count;
    wire         sck_w  = sck_oe ? sck_out : pcpol;
    wire         mosi_w = mosi_oe ? mosi_out : 1'h1;
    wire         miso_w = miso_oe ? miso_out : far_miso;
    spsp_port #(.HALF_BASE(1)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    spsp_far_slave far_u (.sck(sck_w), .mosi(mosi_w), .miso(far_miso), .clock_polarity(pcpol),
        .clock_phase(pcpha), .arm(arm), .tx(tx), .rx(rx));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out;
        $display("TB: checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lost;
        fail_count++;
        $display("[ERR] %0t wait ran out", $time);
        close_out;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= {24'h000000, d};
        psel <= 1'h1;
        penable <= 1'h0;
        @(posedge sys_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) lost;
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            apb(1'h0, OFS_CTRL_STATUS, 8'h00);
            n++;
        end while (q[b] !== 1'h1 && n < 100);
        if (n >= 100) lost;
    endtask
    task automatic arm_far;
        @(posedge sys_clk);
        arm <= 1'h1;
        @(posedge sys_clk);
        arm <= 1'h0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(OFS_CTRL_STATUS, 32'h0);
        rd(OFS_CONTROL, 32'h0);
        rd(8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            cpu_irq_mask <= m[0];
            pcpol <= m[1];
            pcpha <= m[0];
            tx <= 8'h96 + m[7:0];
            apb(1'h1, OFS_CTRL_STATUS, 8'h03);
            apb(1'h1, OFS_CONTROL, {3'h7, m[1:0], 3'h2});
            arm_far;
            apb(1'h1, OFS_DATA, 8'h3A + m[7:0]);
            wait_flag(CSR_DONE);
            chk(q, 32'h83);
            chk({31'h0, irq_req}, {31'h0, ~m[0]});
            rd(OFS_DATA, {24'h0, 8'h96 + m[7:0]});
            chk({24'h0, rx}, {24'h0, 8'h3A + m[7:0]});
            rd(OFS_CTRL_STATUS, 32'h03);
            chk({31'h0, sck_out}, {31'h0, m[1]});
        end
    endtask
    task automatic t_fault;
        for (int c = 0; c < 2; c++) begin
            ss_n_in <= ~c[0];
            apb(1'h1, OFS_CTRL_STATUS, c[0] ? 8'h00 : 8'h02);
            apb(1'h1, OFS_CONTROL, 8'h60);
            repeat (4) @(posedge sys_clk);
            rd(OFS_CTRL_STATUS, c[0] ? 32'h10 : 32'h12);
            rd(OFS_CONTROL, 32'h00);
            chk({31'h0, sck_oe}, 32'h0);
            ss_n_in <= 1'h1;
            apb(1'h1, OFS_CONTROL, 8'h00);
            rd(OFS_CTRL_STATUS, c[0] ? 32'h00 : 32'h02);
        end
    endtask
    task automatic t_sod;
        apb(1'h1, OFS_CTRL_STATUS, 8'h07);
        apb(1'h1, OFS_CONTROL, 8'h62);
        repeat (2) @(posedge sys_clk);
        chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h4);
        apb(1'h1, OFS_CTRL_STATUS, 8'h03);
        repeat (2) @(posedge sys_clk);
        chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h6);
    endtask
    task automatic t_ovr;
        int n;
        pcpol <= 1'h0;
        pcpha <= 1'h0;
        tx <= 8'hA5;
        cpu_irq_mask <= 1'h0;
        apb(1'h1, OFS_CONTROL, 8'hE2);
        arm_far;
        apb(1'h1, OFS_DATA, 8'h3C);
        apb(1'h1, OFS_DATA, 8'hFF);
        n = 0;
        while (irq_req !== 1'h1 && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 400) lost;
        apb(1'h1, OFS_DATA, 8'h55);
        rd(OFS_CTRL_STATUS, 32'hC3);
        chk({24'h0, rx}, 32'h3C);
        tx <= 8'h5A;
        arm_far;
        apb(1'h1, OFS_DATA, 8'h96);
        wait_flag(CSR_OVR);
        chk(q & 32'hA0, 32'hA0);
        rd(OFS_DATA, 32'hA5);
        chk({24'h0, rx}, 32'h96);
        rd(OFS_CTRL_STATUS, 32'h03);
    endtask
    // Bench acts as master: clock on pcpol, mosi idles high
    task automatic t_slave;
        logic [7:0] got;
        got = 8'h00;
        pcpol <= 1'h0;
        pcpha <= 1'h0;
        apb(1'h1, OFS_CTRL_STATUS, 8'h03);
        apb(1'h1, OFS_CONTROL, 8'h40);
        apb(1'h1, OFS_DATA, 8'hC6);
        apb(1'h1, OFS_CTRL_STATUS, 8'h02);
        for (int i = 0; i < 16; i++) begin
            repeat (8) @(posedge sys_clk);
            if (!i[0]) got = {got[6:0], miso_w};
            pcpol <= ~pcpol;
        end
        wait_flag(CSR_DONE);
        chk({24'h0, got}, 32'hC6);
        rd(OFS_DATA, 32'hFF);
        rd(OFS_CTRL_STATUS, 32'h02);
        apb(1'h1, OFS_CTRL_STATUS, 8'h03);
    endtask
    // ----------------------------------------
    // Clock, reset and sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, cpu_irq_mask, ss_n_in, arm, pcpol, pcpha} = 9'h000;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx = 8'h00;
        fail_count = 0;
        check_count = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'h1;
        t_reset;
        t_modes;
        t_fault;
        t_sod;
        t_ovr;
        t_slave;
        close_out;
    end
endmodule
